// [dv/proc_model.sv]
// Purpose: Stand-in for the wakeup and startup procedures.
// Assumes: Start requests are one-cycle pulses.
// Notes: The bench sets the latency, so prompt and slow answers both occur.
`timescale 1ns/1ns
`default_nettype none
module proc_model (
  // Clock, reset and latency.
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] lat,
  // Procedure handshakes.
  input wire logic wakeup_go,
  input wire logic startup_go,
  output logic wakeup_done,
  output logic startup_done
);
  logic [4:0] cnt_q;
  logic wake_q;
  // Only one procedure runs at a time, so one counter serves both.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 5'h00;
      wake_q <= 1'b0;
    end else if (wakeup_go || startup_go) begin
      cnt_q <= {1'b0, lat} + 5'h01;
      wake_q <= wakeup_go;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
  // Done is a single-cycle pulse on the last count.
  assign wakeup_done = cnt_q == 5'h01 && wake_q;
  assign startup_done = cnt_q == 5'h01 && !wake_q;
endmodule : proc_model
`default_nettype wire

// [dv/ready_ctl_checker.sv]
// Purpose: Port checks for ready_ctl.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Terminate, wakeup and status reset pulses are traced back to the command write that caused them.
`timescale 1ns/1ns
`default_nettype none
module ready_ctl_checker (
  // Clock, reset and host bus.
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Strobes, pulses and levels.
  input wire logic [1:0] element_start,
  input wire logic [1:0] idle_point,
  input wire logic cycle_end,
  input wire logic wakeup_go,
  input wire logic startup_go,
  input wire logic status_reset,
  input wire logic terminate_all,
  input wire logic leading_start_inhibit_flag,
  input wire logic [1:0] channel_quiet_flags,
  input wire logic [1:0] frame_mode_a,
  input wire logic [1:0] frame_mode_b,
  input wire logic [1:0] clock_mode
);
  // Code of a command written at this edge, none otherwise.
  logic [3:0] wr_code;
  assign wr_code = (psel && penable && pwrite && paddr == ready_ctl_pkg::OFS_CMD) ?
    pwdata[3:0] : ready_ctl_pkg::CMD_NONE;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_term; terminate_all |-> $past(wr_code) == ready_ctl_pkg::CMD_CONFIG; endproperty
  a_term: assert property (p_term) else $error("terminate without config command");
  property p_wake; wakeup_go |-> $past(wr_code) == ready_ctl_pkg::CMD_WAKEUP; endproperty
  a_wake: assert property (p_wake) else $error("wakeup start without command");
  property p_run; status_reset |-> $past(wr_code) == ready_ctl_pkg::CMD_RUN
    ##1 startup_go; endproperty
  a_run: assert property (p_run) else $error("run order broken");
  property p_inh; $fell(leading_start_inhibit_flag) |->
    $past(wr_code) == ready_ctl_pkg::CMD_ALLOW_COLDSTART; endproperty
  a_inh: assert property (p_inh) else $error("inhibit cleared without command");
  property p_clr; element_start[0] && !idle_point[0] |=> !channel_quiet_flags[0]; endproperty
  a_clr: assert property (p_clr) else $error("quiet flag not cleared");
  property p_set; idle_point[1] |=> channel_quiet_flags[1]; endproperty
  a_set: assert property (p_set) else $error("quiet flag not set");
  property p_pair; frame_mode_a == frame_mode_b; endproperty
  a_pair: assert property (p_pair) else $error("frame modes differ per channel");
  property p_go; $rose(frame_mode_a == ready_ctl_pkg::FRAME_GO) |->
    $past(cycle_end) && clock_mode != ready_ctl_pkg::CLOCK_STANDBY; endproperty
  a_go: assert property (p_go) else $error("go mode outside cycle end");
endmodule : ready_ctl_checker
////////////////////////////////////////////////////////////////////////////////
bind ready_ctl ready_ctl_checker checker_i (.clock(clock), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .element_start(element_start), .idle_point(idle_point), .cycle_end(cycle_end),
  .wakeup_go(wakeup_go), .startup_go(startup_go), .status_reset(status_reset),
  .terminate_all(terminate_all), .leading_start_inhibit_flag(leading_start_inhibit_flag),
  .channel_quiet_flags(channel_quiet_flags), .frame_mode_a(frame_mode_a),
  .frame_mode_b(frame_mode_b), .clock_mode(clock_mode));
`default_nettype wire

// [dv/tb.sv]
// Purpose: Self-checking bench for ready_ctl.
// Assumes: Zero-wait APB slave; proc_model answers start pulses.
// Notes: Status holds state, inhibit, slot mode and quiet flags.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] element_start = 2'b00;
  logic [1:0] idle_point = 2'b00;
  logic cycle_end = 1'b0;
  logic [3:0] lat = 4'h6;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rsp_err, wakeup_done, startup_done, wakeup_go, startup_go;
  logic status_reset, terminate_all;
  logic [1:0] quiet;
  logic [1:0] fa_p, fb_p, cm_p, ma_p, mb_p;
  logic inhibit_p;
  int err_count = 0;
  int tests_run = 0;
  ready_ctl dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .element_start(element_start), .idle_point(idle_point),
    .wakeup_done(wakeup_done), .startup_done(startup_done), .cycle_end(cycle_end),
    .wakeup_go(wakeup_go), .startup_go(startup_go), .status_reset(status_reset),
    .terminate_all(terminate_all), .leading_start_inhibit_flag(inhibit_p),
    .channel_quiet_flags(quiet), .frame_mode_a(fa_p), .frame_mode_b(fb_p),
    .clock_mode(cm_p), .media_mode_a(ma_p), .media_mode_b(mb_p));
  proc_model partner (.clock(clock), .resetn(resetn), .lat(lat), .wakeup_go(wakeup_go),
    .startup_go(startup_go), .wakeup_done(wakeup_done), .startup_done(startup_done));
  // Free-running clock.
  always #4 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  // Counts each comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // The request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    // Start on an edge, so no request signal is driven twice in one time step.
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    rsp_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic cmd(input logic [3:0] c);
    apb(1'b1, ready_ctl_pkg::OFS_CMD, {28'h000_0000, c});
  endtask : cmd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk
  // Reset values, a refused address, commands that ready ignores, and a halt.
  task automatic t_init;
    rd_chk(ready_ctl_pkg::OFS_STATUS, 32'h0000_0008);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({rd[30:0], rsp_err}, 32'h0000_0001);
    cmd(ready_ctl_pkg::CMD_CONFIG_COMPLETE);
    rd_chk(ready_ctl_pkg::OFS_STATUS, 32'h0000_0009);
    cmd(ready_ctl_pkg::CMD_ALL_SLOTS);
    cmd(ready_ctl_pkg::CMD_CONFIG_COMPLETE);
    rd_chk(ready_ctl_pkg::OFS_STATUS, 32'h0000_0009);
    cmd(ready_ctl_pkg::CMD_HALT);
    rd_chk(ready_ctl_pkg::OFS_STATUS, 32'h0000_000E);
    cmd(ready_ctl_pkg::CMD_CONFIG);
    rd_chk(ready_ctl_pkg::OFS_STATUS, 32'h0000_0008);
    cmd(ready_ctl_pkg::CMD_CONFIG_COMPLETE);
    $display("init test done");
  endtask : t_init
  // A slow wakeup must leave the inhibit flag set again.
  task automatic t_wakeup;
    cmd(ready_ctl_pkg::CMD_ALLOW_COLDSTART);
    rd_chk(ready_ctl_pkg::OFS_STATUS, 32'h0000_0001);
    chk(32'(inhibit_p), 32'h0000_0000);
    cmd(ready_ctl_pkg::CMD_WAKEUP);
    chk(32'(wakeup_go), 32'h0000_0001);
    for (int i = 0; i < 40 && wakeup_done !== 1'b1; i++) @(posedge clock);
    #1;
    rd_chk(ready_ctl_pkg::OFS_STATUS, 32'h0000_0009);
    chk(32'(inhibit_p), 32'h0000_0001);
    $display("wakeup test done");
  endtask : t_wakeup
  // Reconfigure, run to normal active, then back to ready.
  task automatic t_cycle(input logic [31:0] cfg, input logic [31:0] modes, input logic [1:0] slot);
    logic [1:0] nxt;
    nxt = (slot == ready_ctl_pkg::SLOT_KEY_SLOT_RESTRICTED_VALUE) ? ready_ctl_pkg::SLOT_ALL_PENDING : slot;
    cmd(ready_ctl_pkg::CMD_CONFIG);
    chk(32'(terminate_all), 32'h0000_0001);
    apb(1'b1, ready_ctl_pkg::OFS_CFG, cfg);
    cmd(ready_ctl_pkg::CMD_CONFIG_COMPLETE);
    rd_chk(ready_ctl_pkg::OFS_STATUS, {26'h000_0000, slot, 4'h9});
    cmd(ready_ctl_pkg::CMD_ALLOW_COLDSTART);
    cmd(ready_ctl_pkg::CMD_RUN);
    chk(32'(status_reset), 32'h0000_0001);
    @(posedge clock);
    #1;
    chk(32'(startup_go), 32'h0000_0001);
    for (int i = 0; i < 40 && startup_done !== 1'b1; i++) @(posedge clock);
    cycle_end <= 1'b1;
    @(posedge clock);
    cycle_end <= 1'b0;
    #1;
    rd_chk(ready_ctl_pkg::OFS_MODES, modes);
    chk({22'h00_0000, mb_p, ma_p, cm_p, fb_p, fa_p}, modes);
    rd_chk(ready_ctl_pkg::OFS_STATUS, {26'h000_0000, slot, 4'h4});
    cmd(ready_ctl_pkg::CMD_ALL_SLOTS);
    cmd(ready_ctl_pkg::CMD_ALL_SLOTS);
    rd_chk(ready_ctl_pkg::OFS_STATUS, {26'h000_0000, nxt, 4'h4});
    cmd(ready_ctl_pkg::CMD_READY);
    apb(1'b0, ready_ctl_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_000F, 32'h0000_0009);
    $display("run test done");
  endtask : t_cycle
  task automatic q_step(input logic [1:0] st, input logic [1:0] ip, input logic [1:0] exp);
    @(posedge clock);
    element_start <= st;
    idle_point <= ip;
    @(posedge clock);
    element_start <= 2'b00;
    idle_point <= 2'b00;
    #1;
    chk(32'(quiet), 32'(exp));
  endtask : q_step
  // Per-channel quiet flags; an idle point wins over a coinciding start.
  task automatic t_quiet;
    q_step(2'b00, 2'b01, 2'b01);
    q_step(2'b00, 2'b10, 2'b11);
    q_step(2'b01, 2'b00, 2'b10);
    q_step(2'b10, 2'b10, 2'b10);
    // Slot mode is still all slots from the last run, so bits 5:4 read 2.
    rd_chk(ready_ctl_pkg::OFS_STATUS, 32'h0000_00A9);
    $display("quiet test done");
  endtask : t_quiet
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; the key-slot run answers slowly, the all-slots run promptly.
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    t_init();
    t_wakeup();
    t_cycle(32'h0000_0003, 32'h0000_0155, ready_ctl_pkg::SLOT_KEY_SLOT_RESTRICTED_VALUE);
    lat <= 4'h0;
    t_cycle(32'h0000_0000, 32'h0000_02A5, ready_ctl_pkg::SLOT_ALL);
    t_quiet();
    conclude();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    conclude();
  end
endmodule : tb
`default_nettype wire

// [logic/quiet_flag.sv]
// Purpose: One channel's quiet flag, cleared at element start, set at idle point.
// Assumes: Strobes are one-cycle pulses on the controller clock.
// Notes: Idle point wins if both strobes coincide.
`timescale 1ns/1ns
`default_nettype none
module quiet_flag (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Bit strobing events.
  input wire logic element_start,
  input wire logic idle_point,
  // Flag out.
  output logic quiet_q
);
  logic quiet_d;

  // Next value of the flag.
  always_comb begin
    quiet_d = quiet_q;
    if (element_start) begin
      quiet_d = 1'b0;
    end
    if (idle_point) begin
      quiet_d = 1'b1;
    end
  end

  // Register the flag.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      quiet_q <= ready_ctl_pkg::RST_QUIET;
    end else begin
      quiet_q <= quiet_d;
    end
  end
endmodule : quiet_flag
`default_nettype wire

// [logic/ready_ctl.sv]
// Purpose: Protocol operation controller path from ready up to normal active.
// Assumes: Wakeup and startup procedures are external and report done pulses.
// Notes: Host commands arrive as APB writes to the command register.
`timescale 1ns/1ns
`default_nettype none
module ready_ctl (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bit strobing events per channel.
  input wire logic [1:0] element_start,
  input wire logic [1:0] idle_point,
  // Procedure handshakes, cycle end, command pulses and status flags.
  input wire logic wakeup_done,
  input wire logic startup_done,
  input wire logic cycle_end,
  output logic wakeup_go,
  output logic startup_go,
  output logic status_reset,
  output logic terminate_all,
  output logic leading_start_inhibit_flag,
  output logic [1:0] channel_quiet_flags,
  // Mechanism modes.
  output logic [1:0] frame_mode_a,
  output logic [1:0] frame_mode_b,
  output logic [1:0] clock_mode,
  output logic [1:0] media_mode_a,
  output logic [1:0] media_mode_b
);
  ////////////////////////////////////////////////////////////////////////////
  ready_ctl_pkg::state_e state_q, state_d;
  logic inhibit_q, inhibit_d;
  logic [1:0] slot_q, slot_d;
  logic key_sync_q, key_sync_d;
  logic key_only_q, key_only_d;
  logic startup_ok_q, startup_ok_d;
  logic wakeup_go_q, wakeup_go_d;
  logic startup_go_q, startup_go_d;
  logic status_reset_q, status_reset_d;
  logic terminate_q, terminate_d;
  logic [1:0] fa_q, fa_d, fb_q, fb_d, cm_q, cm_d, ma_q, ma_d, mb_q, mb_d;
  logic [31:0] prdata_q, prdata_d;
  logic [1:0] quiet_q;
  logic wr_en, rd_en, cmd_wr, cfg_wr, addr_ok;
  logic [3:0] cmd;
  logic pready_q, pready_d, pslverr_q, pslverr_d;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; the slave always answers in the first access cycle.
  assign wr_en = psel && penable && pwrite && pready_q;
  assign rd_en = psel && !penable && !pwrite;
  assign cmd_wr = wr_en && (paddr == ready_ctl_pkg::OFS_CMD);
  assign cfg_wr = wr_en && (paddr == ready_ctl_pkg::OFS_CFG);
  assign cmd = cmd_wr ? pwdata[3:0] : ready_ctl_pkg::CMD_NONE;
  assign addr_ok = (paddr == ready_ctl_pkg::OFS_CMD) || (paddr == ready_ctl_pkg::OFS_CFG) ||
                   (paddr == ready_ctl_pkg::OFS_STATUS) || (paddr == ready_ctl_pkg::OFS_MODES);

  ////////////////////////////////////////////////////////////////////////////
  // One flag per channel, indexed by channel identifier.
  for (genvar ch = 0; ch < ready_ctl_pkg::NUM_CH; ch++) begin : g_quiet
    quiet_flag u_quiet (
      .clock(clock),
      .resetn(resetn),
      .element_start(element_start[ch]),
      .idle_point(idle_point[ch]),
      .quiet_q(quiet_q[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller next state. Pulse outputs drop by default so they last one cycle.
  always_comb begin
    state_d = state_q;
    inhibit_d = inhibit_q;
    slot_d = slot_q;
    key_sync_d = key_sync_q;
    key_only_d = key_only_q;
    startup_ok_d = startup_ok_q;
    wakeup_go_d = 1'b0;
    startup_go_d = 1'b0;
    status_reset_d = 1'b0;
    terminate_d = 1'b0;
    fa_d = fa_q;
    fb_d = fb_q;
    cm_d = cm_q;
    ma_d = ma_q;
    mb_d = mb_q;
    // Configuration is only taken in the configuration state.
    if (cfg_wr && state_q == ready_ctl_pkg::ST_CONFIG) begin
      key_sync_d = pwdata[0];
      key_only_d = pwdata[1];
    end
    unique case (state_q)
      ready_ctl_pkg::ST_CONFIG: begin
        if (cmd == ready_ctl_pkg::CMD_CONFIG_COMPLETE) begin
          state_d = ready_ctl_pkg::ST_READY;
          inhibit_d = 1'b1;
          // Slot mode takes its configured value only here.
          slot_d = key_only_q ? ready_ctl_pkg::SLOT_KEY_SLOT_RESTRICTED_VALUE : ready_ctl_pkg::SLOT_ALL;
        end
      end
      ready_ctl_pkg::ST_READY: begin
        unique case (cmd)
          ready_ctl_pkg::CMD_CONFIG: begin
            terminate_d = 1'b1;
            state_d = ready_ctl_pkg::ST_CONFIG;
          end
          ready_ctl_pkg::CMD_WAKEUP: begin
            wakeup_go_d = 1'b1;
            state_d = ready_ctl_pkg::ST_WAKEUP;
          end
          ready_ctl_pkg::CMD_RUN: begin
            // Status is reset this cycle; startup starts the next one.
            status_reset_d = 1'b1;
            startup_ok_d = 1'b0;
            state_d = ready_ctl_pkg::ST_STARTUP;
          end
          ready_ctl_pkg::CMD_ALLOW_COLDSTART: inhibit_d = 1'b0;
          ready_ctl_pkg::CMD_HALT: state_d = ready_ctl_pkg::ST_HALT;
          default: state_d = state_q;
        endcase
      end
      ready_ctl_pkg::ST_WAKEUP: begin
        if (wakeup_done) begin
          fa_d = ready_ctl_pkg::FRAME_STANDBY;
          fb_d = ready_ctl_pkg::FRAME_STANDBY;
          cm_d = ready_ctl_pkg::CLOCK_STANDBY;
          ma_d = ready_ctl_pkg::MEDIA_STANDBY;
          mb_d = ready_ctl_pkg::MEDIA_STANDBY;
          inhibit_d = 1'b1;
          state_d = ready_ctl_pkg::ST_READY;
        end
      end
      ready_ctl_pkg::ST_STARTUP: begin
        startup_go_d = status_reset_q;
        if (cmd == ready_ctl_pkg::CMD_ALLOW_COLDSTART) begin
          inhibit_d = 1'b0;
        end
        if (cmd == ready_ctl_pkg::CMD_READY) begin
          inhibit_d = 1'b1;
          state_d = ready_ctl_pkg::ST_READY;
        end else if (startup_done) begin
          startup_ok_d = 1'b1;
        end
        // Modes are applied at the end of the cycle in which startup succeeded.
        if ((startup_ok_q || startup_done) && cycle_end && cmd != ready_ctl_pkg::CMD_READY) begin
          fa_d = ready_ctl_pkg::FRAME_GO;
          fb_d = ready_ctl_pkg::FRAME_GO;
          cm_d = key_sync_q ? ready_ctl_pkg::CLOCK_SYNC : ready_ctl_pkg::CLOCK_FOLLOW_ONLY;
          ma_d = (slot_q == ready_ctl_pkg::SLOT_KEY_SLOT_RESTRICTED_VALUE) ? ready_ctl_pkg::MEDIA_KEY_SLOT_ONLY
                                                        : ready_ctl_pkg::MEDIA_ALL;
          mb_d = ma_d;
          state_d = ready_ctl_pkg::ST_NORMAL_ACTIVE;
        end
      end
      ready_ctl_pkg::ST_NORMAL_ACTIVE, ready_ctl_pkg::ST_NORMAL_PASSIVE: begin
        if (cmd == ready_ctl_pkg::CMD_ALLOW_COLDSTART) begin
          inhibit_d = 1'b0;
        end
        if (cmd == ready_ctl_pkg::CMD_ALL_SLOTS && slot_q == ready_ctl_pkg::SLOT_KEY_SLOT_RESTRICTED_VALUE) begin
          slot_d = ready_ctl_pkg::SLOT_ALL_PENDING;
        end
        if (cmd == ready_ctl_pkg::CMD_READY) begin
          inhibit_d = 1'b1;
          state_d = ready_ctl_pkg::ST_READY;
        end else if (cmd == ready_ctl_pkg::CMD_HALT) begin
          state_d = ready_ctl_pkg::ST_HALT;
        end
      end
      ready_ctl_pkg::ST_HALT: begin
        if (cmd == ready_ctl_pkg::CMD_CONFIG) begin
          slot_d = ready_ctl_pkg::RST_SLOT_MODE;
          state_d = ready_ctl_pkg::ST_CONFIG;
        end
      end
      default: state_d = ready_ctl_pkg::ST_CONFIG;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register the controller state.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ready_ctl_pkg::ST_CONFIG;
      inhibit_q <= ready_ctl_pkg::RST_INHIBIT;
      slot_q <= ready_ctl_pkg::RST_SLOT_MODE;
      key_sync_q <= ready_ctl_pkg::RST_KEY_SYNC;
      key_only_q <= ready_ctl_pkg::RST_KEY_ONLY;
      startup_ok_q <= 1'b0;
      wakeup_go_q <= 1'b0;
      startup_go_q <= 1'b0;
      status_reset_q <= 1'b0;
      terminate_q <= 1'b0;
      fa_q <= ready_ctl_pkg::FRAME_STANDBY;
      fb_q <= ready_ctl_pkg::FRAME_STANDBY;
      cm_q <= ready_ctl_pkg::CLOCK_STANDBY;
      ma_q <= ready_ctl_pkg::MEDIA_STANDBY;
      mb_q <= ready_ctl_pkg::MEDIA_STANDBY;
    end else begin
      state_q <= state_d;
      inhibit_q <= inhibit_d;
      slot_q <= slot_d;
      key_sync_q <= key_sync_d;
      key_only_q <= key_only_d;
      startup_ok_q <= startup_ok_d;
      wakeup_go_q <= wakeup_go_d;
      startup_go_q <= startup_go_d;
      status_reset_q <= status_reset_d;
      terminate_q <= terminate_d;
      fa_q <= fa_d;
      fb_q <= fb_d;
      cm_q <= cm_d;
      ma_q <= ma_d;
      mb_q <= mb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle so it comes from a flop.
  always_comb begin
    prdata_d = prdata_q;
    if (rd_en) begin
      prdata_d = 32'h0000_0000;
      if (paddr == ready_ctl_pkg::OFS_CFG) begin
        prdata_d[1:0] = {key_only_q, key_sync_q};
      end else if (paddr == ready_ctl_pkg::OFS_STATUS) begin
        prdata_d[2:0] = state_q;
        prdata_d[3] = inhibit_q;
        prdata_d[5:4] = slot_q;
        prdata_d[7:6] = quiet_q;
      end else if (paddr == ready_ctl_pkg::OFS_MODES) begin
        prdata_d[9:0] = {mb_q, ma_q, cm_q, fb_q, fa_q};
      end
    end
  end

  // Register read data.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus response flags are set at the setup edge so that they come from flops.
  // The price is a fixed single access cycle; no wait states can be added.
  always_comb begin
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && !addr_ok;
  end

  // Register the bus response flags; both drop again at the access edge.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops; error flags an unmapped address.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wakeup_go = wakeup_go_q;
  assign startup_go = startup_go_q;
  assign status_reset = status_reset_q;
  assign terminate_all = terminate_q;
  assign leading_start_inhibit_flag = inhibit_q;
  assign channel_quiet_flags = quiet_q;
  assign frame_mode_a = fa_q;
  assign frame_mode_b = fb_q;
  assign clock_mode = cm_q;
  assign media_mode_a = ma_q;
  assign media_mode_b = mb_q;
endmodule : ready_ctl
`default_nettype wire

// [pkg/ready_ctl_pkg.sv]
// Purpose: Shared constants and types for the ready-to-active controller.
// Assumes: One 125 MHz clock, APB register access.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package ready_ctl_pkg;
  // Controller states.
  typedef enum logic [2:0] {
    ST_CONFIG = 3'b000,
    ST_READY = 3'b001,
    ST_WAKEUP = 3'b010,
    ST_STARTUP = 3'b011,
    ST_NORMAL_ACTIVE = 3'b100,
    ST_NORMAL_PASSIVE = 3'b101,
    ST_HALT = 3'b110
  } state_e;
  // Host command codes written to the command register.
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_CONFIG = 4'h1;
  localparam logic [3:0] CMD_WAKEUP = 4'h2;
  localparam logic [3:0] CMD_RUN = 4'h3;
  localparam logic [3:0] CMD_ALLOW_COLDSTART = 4'h4;
  localparam logic [3:0] CMD_ALL_SLOTS = 4'h5;
  localparam logic [3:0] CMD_HALT = 4'h6;
  localparam logic [3:0] CMD_READY = 4'h7;
  localparam logic [3:0] CMD_CONFIG_COMPLETE = 4'h8;
  // Slot mode values.
  localparam logic [1:0] SLOT_KEY_SLOT_RESTRICTED_VALUE = 2'h0;
  localparam logic [1:0] SLOT_ALL_PENDING = 2'h1;
  localparam logic [1:0] SLOT_ALL = 2'h2;
  // Mechanism mode codes.
  localparam logic [1:0] FRAME_STANDBY = 2'h0;
  localparam logic [1:0] FRAME_GO = 2'h1;
  localparam logic [1:0] CLOCK_STANDBY = 2'h0;
  localparam logic [1:0] CLOCK_SYNC = 2'h1;
  localparam logic [1:0] CLOCK_FOLLOW_ONLY = 2'h2;
  localparam logic [1:0] MEDIA_STANDBY = 2'h0;
  localparam logic [1:0] MEDIA_KEY_SLOT_ONLY = 2'h1;
  localparam logic [1:0] MEDIA_ALL = 2'h2;
  // Channel indices.
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam int NUM_CH = 2;
  // Register byte offsets.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MODES = 8'h0C;
  // Reset values.
  localparam logic [1:0] RST_SLOT_MODE = SLOT_KEY_SLOT_RESTRICTED_VALUE;
  localparam logic RST_INHIBIT = 1'b1;
  localparam logic RST_QUIET = 1'b0;
  localparam logic RST_KEY_SYNC = 1'b0;
  localparam logic RST_KEY_ONLY = 1'b1;
endpackage : ready_ctl_pkg
